// ### rtl/frl_guard.v
// Purpose: read-while-write section control and loader lock guard
// Assumes: CPU issues one-cycle store/load program-memory requests
// Notes: flash timing is a counted window; lock fields only clear by erase or reset
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "frl_map.vh"
module frl_guard #(
	parameter PROG_CYCLES = `FRL_PROG_TIME_NS / `FRL_CLK_NS
) (
	input wire clk,
	input wire reset,
	input wire clk_en,
	input wire [12:0] loader_start,
	input wire [1:0] general_lock,
	input wire vectors_in_loader,
	input wire irq_req,
	input wire [12:0] exec_pc,
	input wire store_req,
	input wire store_page_load,
	input wire [12:0] store_addr,
	input wire lock_set_req,
	input wire [3:0] lock_set_data,
	input wire chip_erase,
	input wire load_req,
	input wire [12:0] load_addr,
	input wire fetch_req,
	input wire [12:0] fetch_addr,
	input wire [1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	output reg cpu_stall,
	output reg prog_start,
	output reg [12:0] prog_addr,
	output reg prog_active,
	output reg load_ok,
	output reg load_refused,
	output reg fetch_ok,
	output reg irq_mask,
	output reg store_refused
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	localparam ST_IDLE = 2'h0;
	localparam ST_RWW = 2'h1;
	localparam ST_HALT = 2'h2;
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [31:0] cnt_reg;
	reg [31:0] cnt_next;
	reg busy_reg;
	reg busy_next;
	reg [1:0] app_lock_reg;
	reg [1:0] loader_lock_reg;
	reg [12:0] paddr_reg;
	wire pc_loader;
	wire st_halting;
	wire st_loader;
	wire ld_halting;
	wire ld_loader;
	wire fe_halting;
	wire fe_loader;
	wire app_store_blk;
	wire app_load_blk;
	wire ldr_store_blk;
	wire ldr_load_blk;
	wire store_allowed;
	wire load_allowed;
	wire fetch_allowed;
	wire reenable_wr;
	wire prog_go;
	// ------------------------------------------------------------
	// Address classification
	// ------------------------------------------------------------
	frl_region u_pc (
		.addr(exec_pc),
		.loader_start(loader_start),
		.in_halting(),
		.in_loader(pc_loader)
	);
	frl_region u_st (
		.addr(store_addr),
		.loader_start(loader_start),
		.in_halting(st_halting),
		.in_loader(st_loader)
	);
	frl_region u_ld (
		.addr(load_addr),
		.loader_start(loader_start),
		.in_halting(ld_halting),
		.in_loader(ld_loader)
	);
	frl_region u_fe (
		.addr(fetch_addr),
		.loader_start(loader_start),
		.in_halting(fe_halting),
		.in_loader(fe_loader)
	);
	// ------------------------------------------------------------
	// Lock decoding
	// ------------------------------------------------------------
	frl_lock u_app (
		.field(app_lock_reg),
		.store_block(app_store_blk),
		.load_block(app_load_blk)
	);
	frl_lock u_ldr (
		.field(loader_lock_reg),
		.store_block(ldr_store_blk),
		.load_block(ldr_load_blk)
	);
	// ------------------------------------------------------------
	// Store decision
	// ------------------------------------------------------------
	// Store is only live from the loader, so application code cannot
	// rewrite the loader behind its back
	wire store_from_loader;
	wire store_target_locked;
	assign store_from_loader = pc_loader;
	// General lock modes never enter here; only the target's own field counts
	assign store_target_locked = st_loader ? ldr_store_blk : app_store_blk;
	assign store_allowed = store_from_loader && !store_target_locked;
	// ------------------------------------------------------------
	// Load decision
	// ------------------------------------------------------------
	wire load_cross_locked;
	wire load_region_dark;
	wire flash_halted;
	// Nothing at all is readable while the halting region is programmed
	assign flash_halted = (state_reg == ST_HALT);
	// The lock fields refuse a load only when it crosses sections against the target field
	assign load_cross_locked = ld_loader ? (!pc_loader && ldr_load_blk) : (pc_loader && app_load_blk);
	// Concurrent region stays dark until software releases the busy flag
	assign load_region_dark = busy_reg && !ld_halting;
	// general_lock is deliberately unused: it never gates these accesses
	assign load_allowed = !load_cross_locked && !load_region_dark && !flash_halted;
	// ------------------------------------------------------------
	// Fetch decision
	// ------------------------------------------------------------
	wire fetch_region_dark;
	assign fetch_region_dark = busy_reg && !fe_halting;
	// Halting-region code keeps running during a concurrent-region program
	assign fetch_allowed = !flash_halted && !fetch_region_dark;
	// ------------------------------------------------------------
	// Busy release and program start
	// ------------------------------------------------------------
	wire ctrl_wr;
	wire page_load_go;
	assign ctrl_wr = reg_wr && (reg_addr == `FRL_REG_CTRL);
	// Re-enable only acts once the counted window is over (idle branch below)
	assign reenable_wr = ctrl_wr && reg_wdata[`FRL_CTRL_REENABLE];
	// A page-buffer load reopens the region too, but must pass the store checks
	assign page_load_go = store_req && store_page_load && store_allowed;
	// A store during a running window is ignored, not queued
	assign prog_go = store_req && !store_page_load && store_allowed && (state_reg == ST_IDLE);
	// ------------------------------------------------------------
	// Programming sequence
	// ------------------------------------------------------------
	always @* begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		busy_next = busy_reg;
		case (state_reg)
		ST_IDLE: begin
			if (prog_go) begin
				// Region chosen by target page, not by the fetch side
				state_next = st_halting ? ST_HALT : ST_RWW;
				cnt_next = PROG_CYCLES - 1;
				// Busy marks only a concurrent-region target; halting is covered by the stall
				busy_next = !st_halting;
			end else if (reenable_wr || page_load_go) begin
				busy_next = 1'b0;
			end
		end
		ST_RWW, ST_HALT: begin
			if (cnt_reg == 32'h0) begin
				state_next = ST_IDLE;
			end else begin
				cnt_next = cnt_reg - 32'h1;
			end
		end
		default: begin
			state_next = ST_IDLE;
		end
		endcase
	end
	// Registers; the busy flag outlives the operation until software releases it
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 32'h0;
			busy_reg <= 1'b0;
			paddr_reg <= 13'h0000;
		end else if (clk_en) begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			busy_reg <= busy_next;
			if (prog_go) begin
				paddr_reg <= store_addr;
			end
		end
	end
	// ------------------------------------------------------------
	// Lock fields
	// ------------------------------------------------------------
	// Programming only drives bits to zero; only chip erase or reset returns ones
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			app_lock_reg <= `FRL_LOCK_RESET;
			loader_lock_reg <= `FRL_LOCK_RESET;
		end else if (clk_en) begin
			if (chip_erase) begin
				app_lock_reg <= `FRL_LOCK_RESET;
				loader_lock_reg <= `FRL_LOCK_RESET;
			end else if ((lock_set_req && pc_loader) ||
				(reg_wr && (reg_addr == `FRL_REG_LOCK))) begin
				// Each field updates on its own bits only
				app_lock_reg <= app_lock_reg & (lock_set_req ? lock_set_data[1:0] : reg_wdata[1:0]);
				loader_lock_reg <= loader_lock_reg & (lock_set_req ? lock_set_data[3:2] : reg_wdata[3:2]);
			end
		end
	end
	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			reg_rdata <= 8'h00;
			cpu_stall <= 1'b0;
			prog_start <= 1'b0;
			prog_addr <= 13'h0000;
			prog_active <= 1'b0;
			load_ok <= 1'b0;
			load_refused <= 1'b0;
			fetch_ok <= 1'b0;
			irq_mask <= 1'b0;
			store_refused <= 1'b0;
		end else if (clk_en) begin
			cpu_stall <= (state_next == ST_HALT);
			prog_start <= prog_go;
			prog_addr <= prog_go ? store_addr : paddr_reg;
			prog_active <= (state_next != ST_IDLE);
			load_ok <= load_req && load_allowed;
			// Refused accesses only show a flag; no error event
			load_refused <= load_req && !load_allowed;
			store_refused <= store_req && !store_allowed;
			fetch_ok <= fetch_req && fetch_allowed;
			// Vector location decides which section masks interrupts
			irq_mask <= irq_req && (vectors_in_loader ? (!pc_loader && app_load_blk)
				: (pc_loader && ldr_load_blk));
			if (reg_rd) begin
				case (reg_addr)
				`FRL_REG_LOCK: reg_rdata <= {4'h0, loader_lock_reg, app_lock_reg};
				`FRL_REG_STAT: reg_rdata <= {1'b0, busy_reg, 4'h0, prog_active, cpu_stall};
				default: reg_rdata <= 8'h00;
				endcase
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end
endmodule

// ### rtl/frl_map.vh
// Purpose: constants for the flash section and lock guard
// Assumes: word addresses of 13 bits, 128-word pages
// Notes: lock bits read one when unprogrammed
`ifndef FRL_MAP_VH
`define FRL_MAP_VH
`define FRL_ADDR_W 13
`define FRL_PAGE_W 7
`define FRL_HALT_START 13'h1C00
`define FRL_LOADER_START 13'h1E00
`define FRL_LOCK_RESET 2'h3
`define FRL_LOCK_UPPER 1
`define FRL_LOCK_LOWER 0
`define FRL_PROG_TIME_NS 4000000
`define FRL_CLK_NS 5
`define FRL_REG_CTRL 2'h0
`define FRL_REG_LOCK 2'h1
`define FRL_REG_STAT 2'h2
`define FRL_CTRL_REENABLE 4
`define FRL_STAT_BUSY 6
`endif

// ### rtl/frl_region.v
// Purpose: classifies a word address into flash sections
// Assumes: the loader section lies above the halting-region limit
// Notes: purely combinational
`timescale 1ns/1ps
module frl_region (
	input wire [12:0] addr,
	input wire [12:0] loader_start,
	output wire in_halting,
	output wire in_loader
);
`include "frl_map.vh"
	// Loader start is clamped so the loader never leaves the halting region
	wire [12:0] ls;
	assign ls = (loader_start < `FRL_HALT_START) ? `FRL_HALT_START : loader_start;
	assign in_halting = (addr >= `FRL_HALT_START);
	assign in_loader = (addr >= ls);
endmodule

// ### rtl/frl_lock.v
// Purpose: decodes one two-bit lock field
// Assumes: bit value one means unprogrammed
// Notes: combinational
`timescale 1ns/1ps
module frl_lock (
	input wire [1:0] field,
	output wire store_block,
	output wire load_block
);
`include "frl_map.vh"
	// Lower bit programmed blocks stores, upper bit programmed blocks cross loads
	assign store_block = ~field[`FRL_LOCK_LOWER];
	assign load_block = ~field[`FRL_LOCK_UPPER];
endmodule

// ### tb/frl_cpu.sv
// Purpose: CPU core model issuing program-memory requests
// Assumes: one request per call
// Notes: released address lines show the inverse value
`timescale 1ns/1ps
module frl_cpu (
	input wire clk,
	output reg store_req,
	output reg load_req,
	output reg fetch_req,
	output reg [12:0] store_addr,
	output reg [12:0] load_addr,
	output reg [12:0] fetch_addr,
	output reg [12:0] exec_pc
);
	initial {store_req, load_req, fetch_req, store_addr, load_addr, fetch_addr, exec_pc} = '0;
	// Kind 0 store, 1 load, 2 fetch, 3 only moves pc
	task req(input logic [1:0] k, input logic [12:0] pc, a);
		@(posedge clk);
		exec_pc <= pc;
		{fetch_req, load_req, store_req} <= 3'h1 << k;
		{store_addr, load_addr, fetch_addr} <= {3{a}};
		@(posedge clk);
		{fetch_req, load_req, store_req} <= 3'h0;
		{store_addr, load_addr, fetch_addr} <= {3{~a}};
	endtask
endmodule

// ### tb/frl_guard_chk.sv
// Purpose: port checks of the flash section guard
// Assumes: halting region starts at 13'h1C00
// Notes: bound after the module
`timescale 1ns/1ps
module frl_guard_chk #(
	parameter PROG_CYCLES = 8
) (
	input wire clk,
	input wire reset,
	input wire clk_en,
	input wire store_req,
	input wire load_req,
	input wire fetch_req,
	input wire [12:0] exec_pc,
	input wire [12:0] fetch_addr,
	input wire [12:0] prog_addr,
	input wire cpu_stall,
	input wire prog_start,
	input wire prog_active,
	input wire load_ok,
	input wire load_refused,
	input wire fetch_ok,
	input wire store_refused
);
	// Length of the current program window
	int run_reg;
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			run_reg <= 0;
		end else begin
			run_reg <= prog_active ? run_reg + 1 : 0;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Fetch taken while halted, halt still on at the answer
	sequence s_halt_fetch;
		fetch_req && clk_en && cpu_stall ##1 cpu_stall;
	endsequence
	a_app_store_dead: assert property (store_req && clk_en && exec_pc < 13'h1C00 |=> !prog_start)
		else $error("app store started");
	a_halt_stalls: assert property (prog_start && prog_addr >= 13'h1C00 |-> cpu_stall)
		else $error("no stall");
	a_rww_runs: assert property (prog_start && prog_addr < 13'h1C00 |-> !cpu_stall)
		else $error("bad stall");
	a_prog_length: assert property ($fell(prog_active) |-> run_reg == PROG_CYCLES)
		else $error("window length");
	a_halted_fetch: assert property (s_halt_fetch |-> !fetch_ok)
		else $error("fetch while halted");
	a_rww_fetch_off: assert property (fetch_req && clk_en && fetch_addr < 13'h1C00 && prog_active |=> !fetch_ok)
		else $error("region read");
	a_refuse_silent: assert property (store_refused |-> !prog_start)
		else $error("refused store ran");
	a_load_answer: assert property (load_req && clk_en |=> load_ok != load_refused)
		else $error("load answer");
endmodule
bind frl_guard frl_guard_chk #(.PROG_CYCLES(PROG_CYCLES)) chk_u (.*);

// ### tb/frl_guard_tb.sv
// Purpose: self-checking bench for the flash section guard
// Assumes: program window shortened to 8 cycles
// Notes: both lock fields swept through all four modes
`timescale 1ns/1ps
module frl_guard_tb;
	localparam PC = 8;
	localparam logic [12:0] LDR = 13'h1E10;
	logic clk = 0, reset = 1, lock_set_req = 0, chip_erase = 0, reg_wr = 0, reg_rd = 0;
	logic vectors_in_loader = 0, irq_req = 0;
	logic clk_en = 1, store_page_load = 0;
	logic [1:0] general_lock = 0, reg_addr = 0;
	logic [3:0] lock_set_data = 0;
	logic [7:0] reg_wdata = 0, reg_rdata;
	logic [12:0] store_addr, load_addr, fetch_addr, exec_pc, prog_addr, ta;
	logic store_req, load_req, fetch_req, cpu_stall, prog_start, prog_active;
	logic load_ok, load_refused, fetch_ok, irq_mask, store_refused;
	int bad_count = 0, cmp_count = 0;
	// --------
	// Clock, parts
	// --------
	always #2.5 clk = ~clk;
	frl_cpu cpu_u (.*);
	frl_guard #(.PROG_CYCLES(PC)) dut_u (.loader_start(13'h1E00), .*);
	// Lock field image for field f set to v
	function automatic logic [3:0] fld(input int f, input logic [1:0] v);
		return f ? {v, 2'h3} : {2'h3, v};
	endfunction
	// A programmed (zero) bit blocks
	function automatic logic blk(input logic [1:0] v, input int b);
		return !v[b];
	endfunction
	task chk(input string n, input logic [12:0] e, g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task bus(input logic w, input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		{reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
		@(posedge clk);
		{reg_wr, reg_rd} <= 2'h0;
		#1;
	endtask
	task edit(input logic [3:0] d, input logic e);
		@(posedge clk);
		{chip_erase, lock_set_req, lock_set_data} <= {e, !e, d};
		@(posedge clk);
		{chip_erase, lock_set_req} <= 2'h0;
	endtask
	task stop_test;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Hang guard, well past the expected run
	initial begin
		#10000;
		bad_count++;
		stop_test;
	end
	// Main sequence
	initial begin
		void'($urandom(29975));
		repeat (4) @(posedge clk);
		reset <= 0;
		bus(0, 1, 0);
		chk("lock", 4'hF, reg_rdata[3:0]);
		bus(0, 3, 0);
		chk("unmapped", 0, reg_rdata);
		cpu_u.req(0, 13'h0010, 13'h0100);
		#1 chk("app store", 1, store_refused);
		$display("test app store done");
		clk_en <= 0;
		cpu_u.req(2, LDR, 13'h0020);
		#1 chk("frozen fetch", 0, fetch_ok);
		clk_en <= 1;
		$display("test freeze done");
		for (int f = 0; f < 2; f++) begin
			for (int v = 0; v < 4; v++) begin
				general_lock <= 2'($urandom);
				ta = f ? LDR + 13'($urandom % 400) : 13'($urandom % 7168);
				cpu_u.req(3, LDR, 0);
				edit(4'hF, 1);
				edit(fld(f, v[1:0]), 0);
				bus(0, 1, 0);
				chk("lock", fld(f, v[1:0]), reg_rdata[3:0]);
				cpu_u.req(1, f ? 13'h0010 : LDR, ta);
				#1 chk("load", blk(v[1:0], 1), load_refused);
				chk("load ok", !blk(v[1:0], 1), load_ok);
				@(posedge clk);
				irq_req <= 1;
				vectors_in_loader <= !f;
				cpu_u.req(3, f ? LDR : 13'h0010, 0);
				@(posedge clk);
				#1 chk("irq mask", blk(v[1:0], 1), irq_mask);
				cpu_u.req(0, LDR, ta);
				#1 chk("store", blk(v[1:0], 0), store_refused);
				chk("stall", f & v[0], cpu_stall);
				chk("prog start", v[0], prog_start);
				if (v[0]) chk("prog addr", ta, prog_addr);
				cpu_u.req(2, LDR, 13'h0020);
				#1 chk("fetch", !v[0], fetch_ok);
				repeat (PC + 2) @(posedge clk);
				bus(0, 2, 0);
				chk("busy", !f & v[0], reg_rdata[6]);
				if (v == 3) begin
					store_page_load <= 1;
					cpu_u.req(0, LDR, ta);
					store_page_load <= 0;
				end else begin
					bus(1, 0, 8'h10);
				end
				bus(0, 2, 0);
				chk("status", 0, reg_rdata);
				$display("test field %0d bits %0d done", f, v);
			end
		end
		stop_test;
	end
endmodule
